// file: rtl/pecg_defs.svh
`ifndef PECG_DEFS_SVH
`define PECG_DEFS_SVH

// ==========================================================
// Register offsets (word addresses on the plain port)
`define PECG_ADDR_W         4
`define PECG_REG_NUM        4'h0
`define PECG_REG_DEN        4'h1
`define PECG_REG_MODE       4'h2
`define PECG_REG_CTRL       4'h3
`define PECG_REG_STATUS     4'h4
`define PECG_REG_ERR        4'h5
`define PECG_REG_POS        4'h6

// ==========================================================
// Reset values
`define PECG_NUM_RST        16'h0001
`define PECG_DEN_RST        16'h0001
`define PECG_MODE_RST       2'h0
`define PECG_CTRL_RST       1'h0

// ==========================================================
// Field positions
`define PECG_CTRL_RESTART   0
`define PECG_ST_LOOP_EN     0
`define PECG_ST_BUSY        1
`define PECG_ST_CLR_IN      2

// ==========================================================
// Widths
`define PECG_CNT_W          32

`endif

// file: rtl/pecg_pkg.sv
package pecg_pkg;

  typedef enum logic [1:0]
  {
    PECG_MODE_SOFF     = 2'h0,
    PECG_MODE_NOCLR    = 2'h1,
    PECG_MODE_SOFF_OT  = 2'h2
  } pecg_mode_t;

  typedef struct packed
  {
    logic servo_on;
    logic overtravel;
    logic zero_clamp;
  } pecg_drive_t;

  typedef struct packed
  {
    logic pulse;
    logic dir_fwd;
  } pecg_ref_t;

endpackage

// file: rtl/pecg_gear.sv
`include "pecg_defs.svh"

module pecg_gear
  import pecg_pkg::*;
#(
  parameter int GW = 16
)
(
  // Clock and reset
  input  wire logic          i_core_clk,
  input  wire logic          i_rstn,
  // Control
  input  wire logic          i_load,
  input  wire logic [GW-1:0] i_num,
  input  wire logic [GW-1:0] i_den,
  input  wire logic          i_step,
  // Result
  output logic               o_emit,
  output logic               o_busy
);

  logic [GW-1:0] num;
  logic [GW-1:0] den;
  logic [GW:0]   rem;

  // Restart-only latching of the gear setting; a zero is raised to one
  always_ff @(posedge i_core_clk)
  begin
    if (!i_rstn)
    begin
      num <= `PECG_NUM_RST;
      den <= `PECG_DEN_RST;
    end
    else if (i_load)
    begin
      num <= (i_num == '0) ? `PECG_NUM_RST : i_num; // R7
      den <= (i_den == '0) ? `PECG_DEN_RST : i_den; // R8
    end
  end

  // Each input pulse adds num to the remainder; one output count is issued
  // per den subtracted. The remainder carries between pulses, so nothing
  // is lost for non-integer ratios. Ratios above one drain at one per cycle.
  logic [GW:0] acc;
  always_comb
  begin
    acc = rem + (i_step ? {1'b0, num} : '0);
  end

  always_ff @(posedge i_core_clk)
  begin
    if (!i_rstn || i_load)
      rem <= '0;
    else if (acc >= {1'b0, den})
      rem <= acc - {1'b0, den}; // R9 R12
    else
      rem <= acc; // R12
  end

  assign o_emit = (!i_load) && (acc >= {1'b0, den}); // R6 R9
  assign o_busy = (rem >= {1'b0, den});

endmodule

// file: rtl/pecg_top.sv
// What this block does
// R1 - Clear input low forces error counter zero
// R2 - Clear input low suspends position loop
// R3 - Default mode clears on servo-off, not overtravel
// R4 - No-clear mode keeps pulses through both events
// R5 - Third mode clears on both, except zero clamp
// R6 - Scale every reference pulse by gear ratio (pulses while the clear input is low or in the restart cycle are dropped)
// R7 - Numerator 1..65535, default 1, on restart
// R8 - Denominator 1..65535, default 1, on restart
// R9 - Ratio is numerator over denominator, multiplies pulses
// R10 - Host keeps ratio between 0.01 and 100
// R11 - Host reduces oversized fractions by common factor
// R12 - Fractional remainder carried into later pulses
//
// Chosen here: the address-and-strobe port and the address map.
`include "pecg_defs.svh"

module pecg_top
  import pecg_pkg::*;
#(
  parameter int GW = 16,
  parameter int CW = `PECG_CNT_W
)
(
  // Clock and reset
  input  wire logic                    i_core_clk,
  input  wire logic                    i_rstn,
  // Register port
  input  wire logic [`PECG_ADDR_W-1:0] i_addr,
  input  wire logic [31:0]             i_wdata,
  input  wire logic                    i_wr,
  input  wire logic                    i_rd,
  output logic [31:0]                  o_rdata,
  // Host reference and clear
  input  wire pecg_ref_t               i_ref,
  input  wire logic                    i_error_counter_clear_n,
  // Drive state
  input  wire pecg_drive_t             i_drive,
  // Feedback from the motor side, one count per pulse
  input  wire pecg_ref_t               i_fb,
  // Position loop
  output logic [CW-1:0]                o_pos_err,
  output logic                         o_loop_en
);

  // ==========================================================
  // Registers
  logic [GW-1:0] gear_ratio_numerator;
  logic [GW-1:0] gear_ratio_denominator;
  pecg_mode_t    clear_mode_setting;
  logic          restart;
  logic [CW-1:0] err_cnt;
  logic [CW-1:0] ref_pos;
  logic          dir_now;
  logic          emit;
  logic          busy;
  logic          auto_clr;
  logic          clr_hold;
  logic          dir_q;

  function automatic logic [CW-1:0] step_cnt(input logic [CW-1:0] v, input logic up);
    step_cnt = up ? v + CW'(1) : v - CW'(1);
  endfunction

  always_ff @(posedge i_core_clk)
  begin
    if (!i_rstn)
    begin
      gear_ratio_numerator   <= `PECG_NUM_RST;
      gear_ratio_denominator <= `PECG_DEN_RST;
      clear_mode_setting     <= pecg_mode_t'(`PECG_MODE_RST);
    end
    else if (i_wr)
    begin
      if (i_addr == `PECG_REG_NUM)
        gear_ratio_numerator <= i_wdata[GW-1:0];
      else if (i_addr == `PECG_REG_DEN)
        gear_ratio_denominator <= i_wdata[GW-1:0];
      else if (i_addr == `PECG_REG_MODE)
        clear_mode_setting <= pecg_mode_t'(i_wdata[1:0]);
    end
  end

  // Restart strobe: gear values only reach the scaler here or at reset
  always_ff @(posedge i_core_clk)
  begin
    if (!i_rstn)
      restart <= 1'b1;
    else
      restart <= i_wr && (i_addr == `PECG_REG_CTRL) && i_wdata[`PECG_CTRL_RESTART]; // R7 R8
  end

  // ==========================================================
  // Read port
  always_ff @(posedge i_core_clk)
  begin
    if (!i_rstn)
      o_rdata <= 32'h0;
    else if (i_rd)
    begin
      if (i_addr == `PECG_REG_NUM)
        o_rdata <= {16'h0, gear_ratio_numerator};
      else if (i_addr == `PECG_REG_DEN)
        o_rdata <= {16'h0, gear_ratio_denominator};
      else if (i_addr == `PECG_REG_MODE)
        o_rdata <= {30'h0, clear_mode_setting};
      else if (i_addr == `PECG_REG_STATUS)
        o_rdata <= {29'h0, !i_error_counter_clear_n, busy, o_loop_en};
      else if (i_addr == `PECG_REG_ERR)
        o_rdata <= err_cnt;
      else if (i_addr == `PECG_REG_POS)
        o_rdata <= ref_pos;
      else
        o_rdata <= 32'h0;
    end
    else
      o_rdata <= 32'h0;
  end

  // ==========================================================
  // Gear scaler
  pecg_gear #(.GW(GW)) u_gear
  (
    .i_core_clk (i_core_clk),
    .i_rstn     (i_rstn),
    .i_load     (restart),
    .i_num      (gear_ratio_numerator),
    .i_den      (gear_ratio_denominator),
    .i_step     (i_ref.pulse && i_error_counter_clear_n),
    .o_emit     (emit),
    .o_busy     (busy)
  );

  // Direction held while the scaler drains a pulse
  always_ff @(posedge i_core_clk)
  begin
    if (!i_rstn)
      dir_q <= 1'b1;
    else if (i_ref.pulse)
      dir_q <= i_ref.dir_fwd;
  end

  // The first count is emitted in the pulse cycle, before dir_q has caught up
  assign dir_now = i_ref.pulse ? i_ref.dir_fwd : dir_q;

  // ==========================================================
  // Automatic clear on drive events, held as a level while the event lasts
  always_comb
  begin
    case (clear_mode_setting)
      PECG_MODE_SOFF:
        auto_clr = !i_drive.servo_on; // R3
      PECG_MODE_NOCLR:
        auto_clr = 1'b0; // R4
      PECG_MODE_SOFF_OT:
        auto_clr = !i_drive.servo_on
                   || (i_drive.overtravel && !i_drive.zero_clamp); // R5
      default:
        auto_clr = 1'b0;
    endcase
  end

  // A held clear keeps the counter pinned at zero for as long as it lasts
  assign clr_hold = !i_error_counter_clear_n || auto_clr;

  // ==========================================================
  // Error counter and reference position
  always_ff @(posedge i_core_clk)
  begin
    if (!i_rstn)
      err_cnt <= '0;
    else if (clr_hold)
      err_cnt <= '0; // R1 R3 R5
    else
    begin
      case ({emit, i_fb.pulse})
        2'b10:
          err_cnt <= step_cnt(err_cnt, dir_now); // R6
        2'b01:
          err_cnt <= step_cnt(err_cnt, !i_fb.dir_fwd);
        2'b11:
          err_cnt <= (dir_now == i_fb.dir_fwd) ? err_cnt
                     : step_cnt(step_cnt(err_cnt, dir_now), dir_now);
        default:
          err_cnt <= err_cnt;
      endcase
    end
  end

  always_ff @(posedge i_core_clk)
  begin
    if (!i_rstn)
      ref_pos <= '0;
    else if (emit)
      ref_pos <= step_cnt(ref_pos, dir_now); // R9
  end

  // Loop output frozen at zero while the clear input is low
  always_ff @(posedge i_core_clk)
  begin
    if (!i_rstn)
    begin
      o_loop_en <= 1'b0;
      o_pos_err <= '0;
    end
    else
    begin
      o_loop_en <= i_error_counter_clear_n; // R2
      o_pos_err <= i_error_counter_clear_n ? err_cnt : '0; // R2
    end
  end

endmodule

// file: bench/pecg_host_model.sv
module pecg_host_model
  import pecg_pkg::*;
(
  // Clock and reset
  input  wire logic       i_core_clk,
  input  wire logic       i_rstn,
  // Burst request
  input  wire logic       i_start,
  input  wire logic [7:0] i_count,
  input  wire logic [7:0] i_gap,
  input  wire logic       i_dir,
  // Reference out
  output pecg_ref_t       o_ref,
  output logic            o_busy
);
  timeunit 1ns;
  timeprecision 1ps;
  // ====
  // Pulse pacing
  logic [7:0] left;
  logic [7:0] idle;
  assign o_busy = left != 8'h00;
  // Direction flips between pulses so a stale level is never trusted
  always_ff @(posedge i_core_clk)
  begin
    o_ref <= '{pulse: 1'b0, dir_fwd: ~o_ref.dir_fwd};
    if (!i_rstn)
    begin
      o_ref <= 2'h0;
      left  <= 8'h00;
      idle  <= 8'h00;
    end
    else if (i_start)
    begin
      left <= i_count;
      idle <= 8'h00;
    end
    else if (o_busy && idle != 8'h00)
      idle <= idle - 8'h01;
    else if (o_busy)
    begin
      o_ref <= '{pulse: 1'b1, dir_fwd: i_dir};
      left  <= left - 8'h01;
      idle  <= i_gap;
    end
  end
endmodule

// file: bench/pecg_checker.sv
`include "pecg_defs.svh"

module pecg_checker
  import pecg_pkg::*;
#(
  parameter int CW = 32
)
(
  // Watched ports
  input wire logic          i_core_clk,
  input wire logic          i_rstn,
  input wire logic [3:0]    i_addr,
  input wire logic          i_rd,
  input wire logic [31:0]   o_rdata,
  input wire logic          i_error_counter_clear_n,
  input wire logic [CW-1:0] o_pos_err,
  input wire logic          o_loop_en
);
  timeunit 1ns;
  timeprecision 1ps;
  // ====
  // Clear and read relations
  wire logic clr_n = i_error_counter_clear_n;
  default clocking cb @(posedge i_core_clk); endclocking
  default disable iff (!i_rstn);
  sequence s_held; !clr_n [*2]; endsequence
  sequence s_rd(logic [3:0] a); i_rd && clr_n && i_addr == a; endsequence
  property p_zero; !clr_n |=> o_pos_err == '0; endproperty
  a_zero: assert property (p_zero) else $error("count kept in clear");
  property p_held; s_held |-> !o_loop_en; endproperty
  a_held: assert property (p_held) else $error("loop live in clear");
  property p_on; clr_n [*2] |-> o_loop_en; endproperty
  a_on: assert property (p_on) else $error("loop not running");
  property p_idle; !i_rd |=> o_rdata == 32'h0; endproperty
  a_idle: assert property (p_idle) else $error("read data outside slot");
  property p_err; s_rd(`PECG_REG_ERR) |=> o_rdata == o_pos_err; endproperty
  a_err: assert property (p_err) else $error("count read mismatch");
  property p_stat; s_rd(`PECG_REG_STATUS) |=>
    o_rdata[0] == $past(o_loop_en) && o_rdata[31:3] == '0; endproperty
  a_stat: assert property (p_stat) else $error("status mismatch");
  property p_gap; i_rd && i_addr > `PECG_REG_POS |=> o_rdata == 32'h0; endproperty
  a_gap: assert property (p_gap) else $error("unmapped read not zero");
  property p_clr_rd; s_held ##0 i_rd && i_addr == `PECG_REG_ERR |=> o_rdata == 32'h0; endproperty
  a_clr_rd: assert property (p_clr_rd) else $error("count read in clear");
endmodule

bind pecg_top pecg_checker #(.CW(CW)) u_chk (.i_core_clk(i_core_clk), .i_rstn(i_rstn),
  .i_addr(i_addr), .i_rd(i_rd), .o_rdata(o_rdata), .o_pos_err(o_pos_err),
  .i_error_counter_clear_n(i_error_counter_clear_n), .o_loop_en(o_loop_en));

// file: bench/pecg_top_bench.sv
`include "pecg_defs.svh"

module pecg_top_bench;
  timeunit 1ns;
  timeprecision 1ps;
  import pecg_pkg::*;
  // ====
  // Signals
  logic        clk;
  logic        rstn;
  logic [3:0]  addr;
  logic [31:0] wdat;
  logic        wr;
  logic        rd;
  logic [31:0] rdat;
  pecg_ref_t   ref_s;
  logic        clr_n;
  pecg_drive_t drv;
  logic [31:0] err;
  logic        loop;
  logic        go;
  logic [7:0]  cnt;
  logic [7:0]  gap;
  logic        busy;
  logic        dirv;
  int          n_fail;
  int          checks;
  pecg_top u_dut (.i_core_clk(clk), .i_rstn(rstn), .i_addr(addr), .i_wdata(wdat),
    .i_wr(wr), .i_rd(rd), .o_rdata(rdat), .i_ref(ref_s), .i_error_counter_clear_n(clr_n),
    .i_drive(drv), .i_fb(2'h0), .o_pos_err(err), .o_loop_en(loop));
  pecg_host_model u_host (.i_core_clk(clk), .i_rstn(rstn), .i_start(go), .i_count(cnt),
    .i_gap(gap), .i_dir(dirv), .o_ref(ref_s), .o_busy(busy));
  // ====
  // Tasks
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp)
    begin
      n_fail++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic wr_reg(input logic [3:0] a, input logic [31:0] d);
    @(posedge clk);
    addr <= a;
    wdat <= d;
    wr   <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  task automatic rd_chk(input logic [3:0] a, input logic [31:0] exp);
    @(posedge clk);
    addr <= a;
    rd   <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1 chk(rdat, exp);
  endtask
  task automatic zap;
    @(posedge clk) clr_n <= 1'b0;
    @(posedge clk) clr_n <= 1'b1;
  endtask
  task automatic burst(input logic [7:0] n, input logic [7:0] g);
    @(posedge clk);
    cnt <= n;
    gap <= g;
    go  <= 1'b1;
    @(posedge clk) go <= 1'b0;
    @(posedge clk);
    while (busy)
      @(posedge clk);
    repeat (g + 8) @(posedge clk);
  endtask
  // Restart then a clean count, so each ratio starts with no remainder
  task automatic gear(input logic [15:0] n, input logic [15:0] d, input logic [7:0] p,
                      input logic [31:0] exp);
    wr_reg(`PECG_REG_NUM, {16'h0, n});
    wr_reg(`PECG_REG_DEN, {16'h0, d});
    rd_chk(`PECG_REG_NUM, {16'h0, n});
    wr_reg(`PECG_REG_CTRL, 32'h1);
    repeat (40) @(posedge clk);
    zap;
    burst(p, 8'(n / d) + 8'h1);
    rd_chk(`PECG_REG_ERR, exp);
    chk(err, exp);
  endtask
  task automatic mode(input logic [1:0] m, input logic [2:0] ev, input logic [31:0] exp);
    wr_reg(`PECG_REG_MODE, {30'h0, m});
    zap;
    burst(8'h3, 8'h2);
    @(posedge clk) drv <= ev;
    repeat (3) @(posedge clk);
    drv <= 3'h4;
    rd_chk(`PECG_REG_ERR, exp);
  endtask
  // Reverse pulses right after forward ones must count down from the first
  task automatic reverse;
    gear(16'h1, 16'h1, 8'h3, 32'h3);
    dirv <= 1'b0;
    burst(8'h2, 8'h2);
    dirv <= 1'b1;
    rd_chk(`PECG_REG_ERR, 32'h1);
    chk(err, 32'h1);
  endtask
  task automatic report_and_stop;
    $display("checks=%0d n_fail=%0d", checks, n_fail);
    if (n_fail == 0 && checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  // ====
  // Sequence
  initial
  begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  initial
  begin
    {rstn, wr, rd, go, addr, wdat, cnt, gap} = '0;
    clr_n = 1'b1;
    dirv = 1'b1;
    drv = 3'h4;
    n_fail = 0;
    checks = 0;
    repeat (10) @(posedge clk);
    rstn <= 1'b1;
    repeat (2) @(posedge clk);
    rd_chk(`PECG_REG_NUM, 32'h1);
    rd_chk(`PECG_REG_DEN, 32'h1);
    rd_chk(`PECG_REG_MODE, 32'h0);
    rd_chk(4'hF, 32'h0);
    gear(16'h1, 16'h1, 8'h5, 32'h5);
    rd_chk(`PECG_REG_STATUS, 32'h1);
    @(posedge clk) clr_n <= 1'b0;
    burst(8'h3, 8'h2);
    rd_chk(`PECG_REG_STATUS, 32'h4);
    chk(err, 32'h0);
    chk({31'h0, loop}, 32'h0);
    rd_chk(`PECG_REG_ERR, 32'h0);
    @(posedge clk) clr_n <= 1'b1;
    rd_chk(`PECG_REG_ERR, 32'h0);
    mode(2'h0, 3'h0, 32'h0);
    mode(2'h0, 3'h6, 32'h3);
    mode(2'h1, 3'h0, 32'h3);
    mode(2'h1, 3'h6, 32'h3);
    mode(2'h2, 3'h0, 32'h0);
    mode(2'h2, 3'h6, 32'h0);
    mode(2'h2, 3'h7, 32'h3);
    mode(2'h3, 3'h0, 32'h3);
    wr_reg(`PECG_REG_NUM, 32'h3);
    zap;
    burst(8'h2, 8'h4);
    rd_chk(`PECG_REG_ERR, 32'h2);
    gear(16'h3, 16'h2, 8'h5, 32'h7);
    gear(16'h1, 16'h4, 8'h7, 32'h1);
    gear(16'h64, 16'h1, 8'h2, 32'hC8);
    gear(16'h1, 16'h64, 8'h96, 32'h1);
    reverse;
    report_and_stop;
  end
  initial
  begin
    repeat (30000) @(posedge clk);
    n_fail++;
    report_and_stop;
  end
endmodule
